/* design/sftrr_defs.svh */
`ifndef SFTRR_DEFS_SVH
`define SFTRR_DEFS_SVH

// Command opcode
`define SFTRR_OPC_READ_TABLE 8'h5A
// Table content
`define SFTRR_UNDEF_BYTE 8'hFF
`define SFTRR_SIG_B0 8'h53
`define SFTRR_SIG_B1 8'h46
`define SFTRR_SIG_B2 8'h44
`define SFTRR_SIG_B3 8'h50
`define SFTRR_REV_MINOR 8'h00
`define SFTRR_REV_MAJOR 8'h01
`define SFTRR_NUM_HDR_M1 8'h01
`define SFTRR_STD_TABLE_ID 8'h00
`define SFTRR_HDR0_LEN 8'h09
`define SFTRR_HDR0_PTR 8'h30
`define SFTRR_HDR1_LEN 8'h03
`define SFTRR_HDR1_PTR 8'h60
`define SFTRR_PTR_HI 8'h00
// Basic byte 0: [1:0]=01 4KB erase, [2]=1 64B gran, [3]=0 NV BP, [7:5]=111
`define SFTRR_BASIC_B0 8'hE5
// Table span; addresses wrap past this
`define SFTRR_TABLE_LAST 24'h0000FF
// Phase lengths in serial clocks
`define SFTRR_OPC_BITS 6'h08
`define SFTRR_HDR_BITS 6'h20

`endif

/* design/sftrr_pkg.sv */
package sftrr_pkg;
    // Protocol phase of the responder
    typedef enum logic [1:0] {
        SFTRR_IDLE,
        SFTRR_OPCODE,
        SFTRR_HEADER,
        SFTRR_STREAM
    } sftrr_phase_e;

    // Sampled pin group
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic mosi;
    } sftrr_pins_s;
endpackage

/* design/sftrr_responder.sv */
`timescale 1ns/1ps
`include "sftrr_defs.svh"
// Notes on behaviour
// - Opcode 5A selects the parameter table
// - Three address bytes, dummy; rising-edge sampling
// - Output changes on falling serial edges
// - Any start address is accepted
// - Address advances after each byte
// - Address wraps to zero past table end
// - Chip select high ends command, releases output
// - Command ignored while array cycle busy
// - Signature and revision bytes 00 to 05
// - Byte 06 holds header count minus one
// - Bytes 07, 0F, 17 fixed at FF
// - First header: id, revision, length nine
// - First header pointer is 30 00 00
// - Second header revision, length, pointer 60
// - Byte 30 bits 1:0 read 01
// - Byte 30 bit 2 reads one
// - Byte 30 bit 3 reads zero
module sftrr_responder
    import sftrr_pkg::*;
#(
    parameter int ADDR_W = 24,
    parameter logic [7:0] VENDOR_ID = 8'hA5 // Arbitrary neutral value
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic array_busy,
    output logic miso,
    output logic miso_oe,
    output logic cmd_active
);

////////////////////////////////////////////////////////////////////////////
// Reset release and input synchronisers

// Reset copy, released two clocks after arst_n rises
logic [1:0] rst_sync;
logic rst_n;

always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        rst_sync <= 2'h0;
    end else begin
        rst_sync <= {rst_sync[0], 1'h1};
    end
end
assign rst_n = rst_sync[1];

// Two-stage pin synchronisers; stage one is read only by stage two
sftrr_pins_s pins_meta;
sftrr_pins_s pins_sync;
sftrr_pins_s pins_last;
logic busy_meta;
logic busy_sync;

always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        pins_meta <= '{cs_n: 1'h1, sclk: 1'h0, mosi: 1'h0};
        pins_sync <= '{cs_n: 1'h1, sclk: 1'h0, mosi: 1'h0};
        pins_last <= '{cs_n: 1'h1, sclk: 1'h0, mosi: 1'h0};
        busy_meta <= 1'h0;
        busy_sync <= 1'h0;
    end else begin
        pins_meta <= '{cs_n: cs_n, sclk: sclk, mosi: mosi};
        pins_sync <= pins_meta;
        pins_last <= pins_sync;
        busy_meta <= array_busy;
        busy_sync <= busy_meta;
    end
end

// Edge detection on the synchronised serial clock
logic sclk_rise;
logic sclk_fall;
logic selected;
assign sclk_rise = pins_sync.sclk & ~pins_last.sclk;
assign sclk_fall = ~pins_sync.sclk & pins_last.sclk;
assign selected = ~pins_sync.cs_n;

////////////////////////////////////////////////////////////////////////////
// Table lookup

// Fixed content; nothing can change it, so FF slots stay FF
function automatic logic [7:0] table_byte(input logic [ADDR_W-1:0] a,
                                           input logic [7:0] vid);
    logic [7:0] b;
    b = `SFTRR_UNDEF_BYTE;
    unique case (a[7:0])
        8'h00: b = `SFTRR_SIG_B0;
        8'h01: b = `SFTRR_SIG_B1;
        8'h02: b = `SFTRR_SIG_B2;
        8'h03: b = `SFTRR_SIG_B3;
        8'h04: b = `SFTRR_REV_MINOR;
        8'h05: b = `SFTRR_REV_MAJOR;
        8'h06: b = `SFTRR_NUM_HDR_M1;
        8'h08: b = `SFTRR_STD_TABLE_ID;
        8'h09: b = `SFTRR_REV_MINOR;
        8'h0A: b = `SFTRR_REV_MAJOR;
        8'h0B: b = `SFTRR_HDR0_LEN;
        8'h0C: b = `SFTRR_HDR0_PTR;
        8'h0D: b = `SFTRR_PTR_HI;
        8'h0E: b = `SFTRR_PTR_HI;
        8'h10: b = vid;
        8'h11: b = `SFTRR_REV_MINOR;
        8'h12: b = `SFTRR_REV_MAJOR;
        8'h13: b = `SFTRR_HDR1_LEN;
        8'h14: b = `SFTRR_HDR1_PTR;
        8'h15: b = `SFTRR_PTR_HI;
        8'h16: b = `SFTRR_PTR_HI;
        8'h30: b = `SFTRR_BASIC_B0;
        default: b = `SFTRR_UNDEF_BYTE;
    endcase
    // Addresses beyond the low 256 hold nothing
    if ((a & ~`SFTRR_TABLE_LAST) != '0) begin
        b = `SFTRR_UNDEF_BYTE;
    end
    return b;
endfunction

////////////////////////////////////////////////////////////////////////////
// Command sequencing

sftrr_phase_e phase;
logic [5:0] bit_cnt; // Bits seen in opcode or header phase
logic [31:0] shift_in; // Opcode, then address and dummy
logic [ADDR_W-1:0] tbl_addr; // Address of byte now shifting out
logic [7:0] out_byte; // Byte being shifted out
logic [2:0] out_bit; // Bits of out_byte already driven
logic [7:0] next_opcode;

assign next_opcode = {shift_in[6:0], pins_sync.mosi};

// Phase machine: leaves idle on the first selected clock, then advances on sampled rising edges only
always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        phase <= SFTRR_IDLE;
        bit_cnt <= 6'h00;
        shift_in <= 32'h0;
    end else if (!selected) begin
        phase <= SFTRR_IDLE;
        bit_cnt <= 6'h00;
    end else begin
        unique case (phase)
            SFTRR_IDLE: begin
                phase <= SFTRR_OPCODE;
                bit_cnt <= 6'h00;
            end
            SFTRR_OPCODE: begin
                if (sclk_rise) begin
                    shift_in <= {shift_in[30:0], pins_sync.mosi};
                    bit_cnt <= bit_cnt + 6'h01;
                    if (bit_cnt == `SFTRR_OPC_BITS - 6'h01) begin
                        bit_cnt <= 6'h00;
                        // Reject while busy so the array cycle is untouched
                        if (next_opcode == `SFTRR_OPC_READ_TABLE
                            && !busy_sync) begin
                            phase <= SFTRR_HEADER;
                        end else begin
                            phase <= SFTRR_STREAM;
                        end
                    end
                end
            end
            SFTRR_HEADER: begin
                if (sclk_rise) begin
                    shift_in <= {shift_in[30:0], pins_sync.mosi};
                    bit_cnt <= bit_cnt + 6'h01;
                    if (bit_cnt == `SFTRR_HDR_BITS - 6'h01) begin
                        phase <= SFTRR_STREAM;
                    end
                end
            end
            SFTRR_STREAM: begin
                phase <= SFTRR_STREAM;
            end
        endcase
    end
end

// Streaming only for an accepted command; rejected ones sit silent
logic streaming;
always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        streaming <= 1'h0;
    end else if (!selected) begin
        streaming <= 1'h0;
    end else if (phase == SFTRR_HEADER && sclk_rise
                 && bit_cnt == `SFTRR_HDR_BITS - 6'h01) begin
        streaming <= 1'h1;
    end
end

// Address load after header, then advance per byte
always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        tbl_addr <= '0;
        out_byte <= 8'h00;
        out_bit <= 3'h0;
    end else if (phase == SFTRR_HEADER && sclk_rise
                 && bit_cnt == `SFTRR_HDR_BITS - 6'h01) begin
        // Address sits in bits 30:7, as the last dummy bit is not shifted in yet; bits 6:0 are dummy
        tbl_addr <= shift_in[30:7];
        out_byte <= table_byte(shift_in[30:7], VENDOR_ID);
        out_bit <= 3'h0;
    end else if (streaming && sclk_fall) begin
        out_bit <= out_bit + 3'h1;
        if (out_bit == 3'h7) begin
            // Wrap keeps the stream going while clocks continue
            if ((tbl_addr & `SFTRR_TABLE_LAST) == `SFTRR_TABLE_LAST) begin
                tbl_addr <= '0;
                out_byte <= table_byte('0, VENDOR_ID);
            end else begin
                tbl_addr <= tbl_addr + ADDR_W'(1);
                out_byte <= table_byte(tbl_addr + ADDR_W'(1), VENDOR_ID);
            end
        end
    end
end

// Output pin: MSB first, updated on each falling edge
always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        miso <= 1'h0;
        miso_oe <= 1'h0;
    end else if (!selected) begin
        miso_oe <= 1'h0;
        miso <= 1'h0;
    end else if (streaming && sclk_fall) begin
        miso_oe <= 1'h1;
        miso <= out_byte[3'h7 - out_bit];
    end else if (!streaming) begin
        miso_oe <= 1'h0;
    end
end

// Status flag for the surrounding device
always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        cmd_active <= 1'h0;
    end else begin
        cmd_active <= streaming & selected;
    end
end

////////////////////////////////////////////////////////////////////////////
// Checks

// Opcode complete, array idle, still selected
sequence s_accept;
    phase == SFTRR_OPCODE && sclk_rise && bit_cnt == 6'h07
        && next_opcode == 8'h5A && !busy_sync && selected;
endsequence

// Opcode complete while an array cycle runs
sequence s_busy_end;
    phase == SFTRR_OPCODE && sclk_rise && bit_cnt == 6'h07
        && busy_sync && selected;
endsequence

// Last dummy bit sampled; data starts at the next fall
sequence s_header_done;
    phase == SFTRR_HEADER && sclk_rise && bit_cnt == 6'h1F && selected;
endsequence

// Last bit of a byte driven; the address moves on
sequence s_byte_end;
    streaming && sclk_fall && out_bit == 3'h7;
endsequence

// Fresh byte loaded, no bit of it driven yet
sequence s_byte_start;
    streaming && out_bit == 3'h0;
endsequence

// Command decode and release
AST_OPCODE_ACCEPT: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_accept |=> phase == SFTRR_HEADER)
    else $error("Opcode 5A not accepted");
AST_BUSY_REJECT: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_busy_end |=> phase == SFTRR_STREAM && !streaming)
    else $error("Command accepted while busy");
AST_REJECT_SILENT: assert property (
    @(posedge clk) disable iff (!rst_n)
    phase == SFTRR_STREAM && !streaming |=> !miso_oe)
    else $error("Rejected command drives output");
AST_CS_RELEASE: assert property (
    @(posedge clk) disable iff (!rst_n)
    !selected |=> !miso_oe && !streaming)
    else $error("Output driven after deselect");
AST_HDR_QUIET: assert property (
    @(posedge clk) disable iff (!rst_n)
    phase == SFTRR_HEADER |=> !miso_oe)
    else $error("Output driven before data phase");
AST_HDR_DONE: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_header_done |=> streaming && phase == SFTRR_STREAM && out_bit == 3'h0)
    else $error("Data phase not entered after dummy byte");

// Output timing and address walk
AST_DATA_DRIVE: assert property (
    @(posedge clk) disable iff (!rst_n)
    streaming && sclk_fall && selected |=> miso_oe)
    else $error("Output not driven in data phase");
AST_FALL_ONLY: assert property (
    @(posedge clk) disable iff (!rst_n)
    $changed(miso) && selected && $past(selected) |-> $past(sclk_fall))
    else $error("Output changed off falling edge");
AST_ADDR_STEP: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_byte_end ##0 tbl_addr[7:0] != 8'hFF
    |=> tbl_addr == $past(tbl_addr) + 24'h1)
    else $error("Address did not advance");
AST_ADDR_WRAP: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_byte_end ##0 tbl_addr[7:0] == 8'hFF |=> tbl_addr == 24'h0)
    else $error("Address did not wrap");

// Table content as it is shifted out
AST_SIG_BYTE: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_byte_start ##0 tbl_addr == 24'h0 |-> out_byte == 8'h53)
    else $error("Signature byte wrong");
AST_MAJOR_REV: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_byte_start ##0 tbl_addr == 24'h5 |-> out_byte == 8'h01)
    else $error("Major revision wrong");
AST_HDR_COUNT: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_byte_start ##0 tbl_addr == 24'h6 |-> out_byte == 8'h01)
    else $error("Header count wrong");
AST_PAD_FF: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_byte_start ##0 (tbl_addr == 24'h7 || tbl_addr == 24'hF
        || tbl_addr == 24'h17) |-> out_byte == 8'hFF)
    else $error("Unused header byte not FF");
AST_HDR0_LEN: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_byte_start ##0 tbl_addr == 24'hB |-> out_byte == 8'h09)
    else $error("First header length wrong");
AST_HDR0_PTR: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_byte_start ##0 tbl_addr == 24'hC |-> out_byte == 8'h30)
    else $error("First header pointer wrong");
AST_HDR1_PTR: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_byte_start ##0 tbl_addr == 24'h14 |-> out_byte == 8'h60)
    else $error("Second header pointer wrong");
AST_BASIC_BYTE: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_byte_start ##0 tbl_addr == 24'h30 |-> out_byte == 8'hE5)
    else $error("Basic table byte wrong");
AST_UNDEF_FF: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_byte_start ##0 tbl_addr > 24'h30 |-> out_byte == 8'hFF)
    else $error("Undefined table byte not FF");

endmodule

/* test/sftrr_host.sv */
`timescale 1ns/1ps
// Host side of the serial link; the clock runs only inside frames
module sftrr_host (
    input wire logic clk,
    input wire logic miso,
    input wire logic miso_oe,
    output logic cs_n,
    output logic sclk,
    output logic mosi
);
    logic [7:0] rx [0:299]; // Bytes gathered in the data phase
    logic oe_early; // Output seen enabled before the data phase
    logic oe_gap; // Output seen disabled at some data sample
    logic oe_data; // Output seen enabled at some data sample

    // Idle levels: deselected, serial clock parked low
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        mosi = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // One serial cycle of 8 system clocks; the caller samples at its end,
    // just before the next fall, so the device has the whole high phase
    task automatic cycle(input logic b);
        sclk = 1'b0;
        mosi = b;
        repeat (4) @(negedge clk);
        sclk = 1'b1;
        repeat (4) @(negedge clk);
    endtask

    // Whole frame; nbits not a multiple of 8 aborts mid-byte
    task automatic xfer(input logic [7:0] opc, input logic [23:0] adr,
                        input int nbits);
        logic [31:0] cmd;
        cmd = {opc, adr};
        oe_early = 1'b0;
        oe_gap = 1'b0;
        oe_data = 1'b0;
        cs_n = 1'b0;
        mosi = ~mosi;
        repeat (4) @(negedge clk);
        for (int i = 31; i >= 0; i--) begin
            cycle(cmd[i]);
            oe_early |= miso_oe;
        end
        // Dummy bits toggle so the device cannot lean on them
        for (int i = 0; i < 8; i++) begin
            cycle(i[0]);
            oe_early |= miso_oe;
        end
        // Input keeps toggling, as a stale level would hide faults
        for (int i = 0; i < nbits; i++) begin
            cycle(~mosi);
            oe_gap |= ~miso_oe;
            oe_data |= miso_oe;
            rx[i / 8] = {rx[i / 8][6:0], miso};
        end
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = ~mosi;
    endtask
endmodule

/* test/sftrr_responder_bench.sv */
`timescale 1ns/1ps
// Self-checking bench for the parameter table responder
module sftrr_responder_bench;
    localparam logic [7:0] VID = 8'h3C; // Arbitrary test value
    logic clk; // System clock
    logic arst_n; // Asynchronous reset
    logic array_busy; // Array cycle in progress
    logic cs_n, sclk, mosi, miso, miso_oe, cmd_active;
    int error_cnt;
    int comparisons;
    logic act_seen; // Status flag seen high in the current frame

    sftrr_responder #(.ADDR_W(24), .VENDOR_ID(VID)) i_sftrr_responder (
        .clk(clk), .arst_n(arst_n), .cs_n(cs_n), .sclk(sclk),
        .mosi(mosi), .array_busy(array_busy), .miso(miso),
        .miso_oe(miso_oe), .cmd_active(cmd_active));
    sftrr_host i_sftrr_host (.clk(clk), .miso(miso), .miso_oe(miso_oe),
        .cs_n(cs_n), .sclk(sclk), .mosi(mosi));

    // 125 MHz system clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Expected header bytes 00 to 17
    localparam logic [7:0] HDR [0:23] = '{
        8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01,
        8'h01, 8'hFF,
        8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hFF,
        VID, 8'h00, 8'h01, 8'h03, 8'h60, 8'h00, 8'h00, 8'hFF};

    // Expected byte at any address; upper address bits select nothing
    function automatic logic [7:0] tbl(input logic [23:0] a);
        if (a[23:8] != 16'h0000) return 8'hFF;
        if (a[7:0] < 8'h18) return HDR[a[4:0]];
        if (a[7:0] == 8'h30) return 8'hE5;
        return 8'hFF;
    endfunction

    // Status flag monitor, sampled away from the edge that launches it
    always @(negedge clk) begin
        if (cmd_active) begin
            act_seen = 1'b1;
        end
    end

    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // After deselect the output must be released within a few clocks
    task automatic idle_check();
        repeat (6) @(negedge clk);
        check({6'h00, miso_oe, cmd_active}, 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Stream n bytes from a start address and follow the address walk
    task automatic t_stream(input logic [23:0] start, input int n);
        logic [23:0] a;
        a = start;
        act_seen = 1'b0;
        i_sftrr_host.xfer(8'h5A, start, n * 8);
        check({7'h00, i_sftrr_host.oe_early}, 8'h00);
        check({7'h00, i_sftrr_host.oe_gap}, 8'h00);
        check({7'h00, act_seen}, 8'h01);
        for (int i = 0; i < n; i++) begin
            check(i_sftrr_host.rx[i], tbl(a));
            a = (a[7:0] == 8'hFF) ? 24'h000000 : a + 24'h000001;
        end
        idle_check();
    endtask

    // Deselect in the middle of the second byte, then read again
    task automatic t_abort();
        i_sftrr_host.xfer(8'h5A, 24'h00000C, 11);
        check(i_sftrr_host.rx[0], 8'h30);
        idle_check();
        t_stream(24'h00000C, 2);
    endtask

    // A foreign opcode or a busy array must leave the output off
    task automatic t_reject(input logic [7:0] opc, input logic busy);
        array_busy = busy;
        act_seen = 1'b0;
        i_sftrr_host.xfer(opc, 24'h000000, 16);
        array_busy = 1'b0;
        check({7'h00, i_sftrr_host.oe_early}, 8'h00);
        check({7'h00, i_sftrr_host.oe_data}, 8'h00);
        check({7'h00, act_seen}, 8'h00);
        idle_check();
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic print_verdict();
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        error_cnt = 0;
        comparisons = 0;
        act_seen = 1'b0;
        arst_n = 1'b0;
        array_busy = 1'b0;
        repeat (5) @(negedge clk);
        arst_n = 1'b1;
        repeat (8) @(negedge clk);
        check({6'h00, miso_oe, cmd_active}, 8'h00);
        // Full table plus a few bytes past the wrap
        t_stream(24'h000000, 264);
        t_stream(24'h0100FE, 4);
        t_stream(24'h000007, 3);
        t_abort();
        t_reject(8'h03, 1'b0);
        t_reject(8'h5B, 1'b0);
        t_reject(8'hDA, 1'b0);
        t_reject(8'h5A, 1'b1);
        t_stream(24'h000010, 1);
        print_verdict();
    end

    // Watchdog: the sequence needs about 21450 clocks
    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        print_verdict();
    end
endmodule
